// file: hdl/pdcfg_defs.svh
// offsets, field masks, reset values and timing counts of the config bank
// assumes a 100 MHz core clock and a 7-bit register address
`ifndef PDCFG_DEFS_SVH
`define PDCFG_DEFS_SVH

// ==========================================================================
// register offsets
`define PDCFG_OFS_DIAG_SUPPLY    7'h00
`define PDCFG_OFS_WDT_THERMAL    7'h01
`define PDCFG_OFS_SUPPLY_PROT    7'h02
`define PDCFG_OFS_BACKUP_LOCK    7'h03
`define PDCFG_OFS_WDT_DRIVE      7'h04
`define PDCFG_OFS_OC_BLANK       7'h05
`define PDCFG_OFS_SHORT_TIMING   7'h06
`define PDCFG_OFS_FAULT_DEAD     7'h07
`define PDCFG_OFS_RUNTIME_LOCK   7'h08
`define PDCFG_OFS_RESET_CMD      7'h15
`define PDCFG_OFS_FLAGS_FIRST    7'h20
`define PDCFG_OFS_FLAGS_SECOND   7'h21
`define PDCFG_NUM_CFG            9

// ==========================================================================
// implemented bits per register, reset value, commands
`define PDCFG_MASK_0             8'h3f
`define PDCFG_MASK_1             8'h1f
`define PDCFG_MASK_2             8'h3f
`define PDCFG_MASK_3             8'h01
`define PDCFG_MASK_4             8'h77
`define PDCFG_MASK_5             8'h3f
`define PDCFG_MASK_6             8'h0f
`define PDCFG_MASK_7             8'hff
`define PDCFG_MASK_8             8'h01
`define PDCFG_CFG_RESET          8'h00
`define PDCFG_CMD_WDT_RESTART    8'h00
`define PDCFG_CMD_LATCH_RELEASE  8'hff

// ==========================================================================
// timing
`define PDCFG_CLK_MHZ            100
`define PDCFG_BLANK_STEP_NS      200
`define PDCFG_DEBOUNCE_STEP_NS   800
`define PDCFG_SHORT_MASK_STEP_NS 3200
`define PDCFG_BLANK_STEP_CYC     ((`PDCFG_BLANK_STEP_NS*`PDCFG_CLK_MHZ+999)/1000)
`define PDCFG_DEBOUNCE_STEP_CYC  ((`PDCFG_DEBOUNCE_STEP_NS*`PDCFG_CLK_MHZ+999)/1000)
`define PDCFG_SHORT_MASK_STEP_CYC ((`PDCFG_SHORT_MASK_STEP_NS*`PDCFG_CLK_MHZ+999)/1000)
`define PDCFG_DEAD_CODES         16
`define PDCFG_WDT_FIRST_US       409600
`define PDCFG_WDT_CLOSED_US      102400
`define PDCFG_WDT_WINDOW_US      204800
`define PDCFG_RELOAD_US          200000
`define PDCFG_WDT_FIRST_CYC      (`PDCFG_WDT_FIRST_US*`PDCFG_CLK_MHZ)
`define PDCFG_WDT_CLOSED_CYC     (`PDCFG_WDT_CLOSED_US*`PDCFG_CLK_MHZ)
`define PDCFG_WDT_WINDOW_CYC     (`PDCFG_WDT_WINDOW_US*`PDCFG_CLK_MHZ)
`define PDCFG_RELOAD_CYC         (`PDCFG_RELOAD_US*`PDCFG_CLK_MHZ)

// ==========================================================================
// thresholds
`define PDCFG_TEMP_LOW_C         8'd125
`define PDCFG_TEMP_MID_C         8'd150
`define PDCFG_TEMP_HIGH_C        8'd175
`define PDCFG_OC_MV_0            8'd200
`define PDCFG_OC_MV_1            8'd150
`define PDCFG_OC_MV_2            8'd100

`endif

// file: hdl/pdcfg_pkg.sv
// types shared by the predriver config bank
// assumes nothing beyond the defs header
package pdcfg_pkg;

  // ========================================================================
  // serial frame phases
  typedef enum logic [3:0] {
    PDCFG_IDLE = 4'b0001,
    PDCFG_ADDR = 4'b0010,
    PDCFG_DATA = 4'b0100,
    PDCFG_WAIT = 4'b1000
  } pdcfg_phase_e;

  // ========================================================================
  // nonvolatile backup image, decoded controls
  typedef struct packed {
    logic       backup_config_write_lock;
    logic [7:0] supply_prot;
    logic [7:0] wdt_thermal;
    logic [7:0] diag_supply;
  } pdcfg_nv_s;

  typedef struct packed {
    logic        thermal_threshold_select;
    logic [7:0]  warn_temp_c;
    logic [7:0]  shutdown_temp_c;
    logic        gate_voltage_select;
    logic        regulator_voltage_select;
    logic        sense_offset_select;
    logic        three_input_drive_select;
    logic [1:0]  overcurrent_threshold_code;
    logic [7:0]  overcurrent_threshold_mv;
    logic [8:0]  oc_blank_cycles;
    logic [8:0]  short_debounce_cycles;
    logic [10:0] short_blank_cycles;
    logic [8:0]  min_dead_cycles;
    logic [2:0]  watchdog_window_code;
    logic [31:0] wdt_first_cycles;
    logic [31:0] wdt_closed_cycles;
    logic [31:0] wdt_window_cycles;
  } pdcfg_ctl_s;

  typedef logic [1:0] pdcfg_resp_t;

endpackage

// file: hdl/pdcfg_bank.sv
// predriver protection config bank with its serial slave and fault response
// assumes mode-0 serial master, async pins, fault inputs high while present
`timescale 1ns/1ps
`include "pdcfg_defs.svh"

module pdcfg_bank
  import pdcfg_pkg::*;
#(
  parameter logic [31:0] WDT_FIRST_CYC  = `PDCFG_WDT_FIRST_CYC,
  parameter logic [31:0] WDT_CLOSED_CYC = `PDCFG_WDT_CLOSED_CYC,
  parameter logic [31:0] WDT_WINDOW_CYC = `PDCFG_WDT_WINDOW_CYC,
  parameter logic [31:0] RELOAD_CYC     = `PDCFG_RELOAD_CYC
) (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       sclk,
  input  wire logic       cs_n,
  input  wire logic       mosi,
  output logic            miso,
  input  wire logic       drive_enable,
  input  wire pdcfg_nv_s  nv_config,
  input  wire logic [8:0] fault_in,
  output pdcfg_ctl_s      ctl,
  output logic            emergency_off,
  output logic            latched_off,
  output logic            fault_pin,
  output logic [8:0]      fault_flags,
  output logic            wdt_restart,
  output logic            nv_reload
);

  // ========================================================================
  // pin synchronisers
  logic [12:0]  sync1_reg;
  logic [12:0]  sync2_reg;
  logic         sclk_d_reg;
  wire  logic   sclk_s = sync2_reg[0];
  wire  logic   cs_n_s = sync2_reg[1];
  wire  logic   mosi_s = sync2_reg[2];
  wire  logic   en_s   = sync2_reg[3];
  wire  logic [8:0] err_s = sync2_reg[12:4];
  wire  logic   sclk_rise = sclk_s & ~sclk_d_reg;
  wire  logic   sclk_fall = ~sclk_s & sclk_d_reg;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sync1_reg  <= 13'h0002;
      sync2_reg  <= 13'h0002;
      sclk_d_reg <= 1'b0;
    end else begin
      sync1_reg  <= {fault_in, drive_enable, mosi, cs_n, sclk};
      sync2_reg  <= sync1_reg;
      sclk_d_reg <= sclk_s;
    end
  end

  // ========================================================================
  // serial frame: rw bit, 7-bit address, 8 data bits, msb first
  pdcfg_phase_e phase_reg;
  pdcfg_phase_e phase_next;
  logic [3:0]   bit_cnt_reg;
  logic [6:0]   shift_reg;
  logic         rw_reg;
  logic [6:0]   addr_reg;
  logic [7:0]   tx_reg;
  logic         miso_reg;
  logic [7:0]   rdata;

  wire logic [7:0] rx_byte   = {shift_reg, mosi_s};
  wire logic       last_rise = sclk_rise & (bit_cnt_reg == 4'd15);
  wire logic       frame_end = last_rise & (phase_reg == PDCFG_DATA);
  wire logic       wr_frame  = frame_end & rw_reg;
  wire logic       rd_frame  = frame_end & ~rw_reg;

  always_comb begin
    phase_next = phase_reg;
    case (phase_reg)
      PDCFG_IDLE: begin
        if (!cs_n_s) phase_next = PDCFG_ADDR;
      end
      PDCFG_ADDR: begin
        if (cs_n_s) phase_next = PDCFG_IDLE;
        else if (sclk_rise && bit_cnt_reg == 4'd7) phase_next = PDCFG_DATA;
      end
      PDCFG_DATA: begin
        if (cs_n_s) phase_next = PDCFG_IDLE;
        else if (last_rise) phase_next = PDCFG_WAIT;
      end
      PDCFG_WAIT: begin
        if (cs_n_s) phase_next = PDCFG_IDLE;
      end
      default: phase_next = PDCFG_IDLE;
    endcase
  end

  wire logic load_tx = sclk_fall & (phase_reg == PDCFG_DATA) &
                       (bit_cnt_reg == 4'd8);
  wire logic shift_tx = sclk_fall & (phase_reg == PDCFG_DATA) &
                        (bit_cnt_reg > 4'd8);

  always_ff @(posedge core_clk) begin
    if (!rst_n || cs_n_s) begin
      bit_cnt_reg <= 4'h0;
      shift_reg   <= 7'h00;
    end else if (sclk_rise) begin
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
      shift_reg   <= rx_byte[6:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      phase_reg <= PDCFG_IDLE;
      rw_reg    <= 1'b0;
      addr_reg  <= 7'h00;
      tx_reg    <= 8'h00;
      miso_reg  <= 1'b0;
    end else begin
      phase_reg <= phase_next;
      if (phase_reg == PDCFG_ADDR && sclk_rise && bit_cnt_reg == 4'd7) begin
        rw_reg   <= rx_byte[7];
        addr_reg <= rx_byte[6:0];
      end
      if (phase_next != PDCFG_DATA) begin
        miso_reg <= 1'b0;
      end else if (load_tx) begin
        tx_reg   <= rdata;
        miso_reg <= rdata[7];
      end else if (shift_tx) begin
        tx_reg   <= {tx_reg[6:0], 1'b0};
        miso_reg <= tx_reg[6];
      end
    end
  end

  // ========================================================================
  // config registers
  localparam logic [7:0] CFG_MASK [0:8] = '{`PDCFG_MASK_0, `PDCFG_MASK_1,
    `PDCFG_MASK_2, `PDCFG_MASK_3, `PDCFG_MASK_4, `PDCFG_MASK_5,
    `PDCFG_MASK_6, `PDCFG_MASK_7, `PDCFG_MASK_8};

  logic [7:0]  cfg_reg  [0:8];
  logic [7:0]  cfg_next [0:8];
  logic [31:0] reload_cnt_reg;
  logic        reload_reg;
  logic        wdt_restart_reg;

  wire logic [7:0] nv_byte [0:3] = '{nv_config.diag_supply,
    nv_config.wdt_thermal, nv_config.supply_prot,
    {7'h00, nv_config.backup_config_write_lock}};
  wire logic backup_lock  = cfg_reg[3][0];
  wire logic runtime_lock = cfg_reg[8][0];
  wire logic cfg_wr_ok    = wr_frame & ~en_s;
  wire logic reload_hit   = reload_reg;

  genvar gi;
  generate
    for (gi = 0; gi < `PDCFG_NUM_CFG; gi++) begin : g_cfg
      localparam logic [6:0] OFS = 7'(gi);
      localparam logic LOCK_BK = (gi <= 2);
      localparam logic LOCK_RT = (gi >= 4) && (gi <= 7);
      localparam logic WRITABLE = (gi != 3);
      wire logic locked = (LOCK_BK & backup_lock) | (LOCK_RT & runtime_lock);
      wire logic hit = cfg_wr_ok & WRITABLE & ~locked & (addr_reg == OFS);
      wire logic nv_hit = reload_hit & (gi <= 3);
      assign cfg_next[gi] = nv_hit ? (nv_byte[gi & 3] & CFG_MASK[gi]) :
                            hit    ? (rx_byte & CFG_MASK[gi]) : cfg_reg[gi];
    end
  endgenerate

  // periodic backup reload while enable high and reload bit set
  wire logic reload_run = en_s & cfg_reg[4][1];
  wire logic reload_due = reload_run & (reload_cnt_reg >= RELOAD_CYC - 32'd1);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < `PDCFG_NUM_CFG; i++) begin
        cfg_reg[i] <= `PDCFG_CFG_RESET;
      end
      reload_cnt_reg  <= 32'h0;
      reload_reg      <= 1'b0;
      wdt_restart_reg <= 1'b0;
    end else begin
      for (int i = 0; i < `PDCFG_NUM_CFG; i++) begin
        cfg_reg[i] <= cfg_next[i];
      end
      reload_cnt_reg  <= (!reload_run || reload_due) ? 32'h0 :
                         reload_cnt_reg + 32'h1;
      reload_reg      <= reload_due;
      wdt_restart_reg <= wr_frame & (addr_reg == `PDCFG_OFS_RESET_CMD) &
                         (rx_byte == `PDCFG_CMD_WDT_RESTART);
    end
  end

  // ========================================================================
  // fault responses: 0 ignore, 1 report, 2 auto-off, 3 latched off
  pdcfg_resp_t resp [0:8];
  logic [8:0]  flag_reg;
  logic [8:0]  flag_next;
  logic        latch_reg;
  logic        eoff_reg;
  logic        fault_pin_reg;

  function automatic pdcfg_resp_t sat_resp(input logic [1:0] code);
    sat_resp = {code[1], code[0] & ~code[1]};
  endfunction

  assign resp[0] = cfg_reg[7][5:4];
  assign resp[1] = cfg_reg[7][7:6];
  assign resp[2] = {1'b0, cfg_reg[1][2]};
  assign resp[3] = {cfg_reg[1][3], 1'b0};
  assign resp[4] = {cfg_reg[1][4], 1'b0};
  assign resp[5] = sat_resp(cfg_reg[2][1:0]);
  assign resp[6] = sat_resp(cfg_reg[2][3:2]);
  assign resp[7] = sat_resp(cfg_reg[2][5:4]);
  assign resp[8] = sat_resp(cfg_reg[1][1:0]);

  wire logic clear_on_recover = cfg_reg[0][4];
  wire logic rd_first  = rd_frame & (addr_reg == `PDCFG_OFS_FLAGS_FIRST);
  wire logic rd_second = rd_frame & (addr_reg == `PDCFG_OFS_FLAGS_SECOND);
  wire logic latch_release = wr_frame &
                             (addr_reg == `PDCFG_OFS_RESET_CMD) &
                             (rx_byte == `PDCFG_CMD_LATCH_RELEASE);
  logic [8:0] auto_off;
  logic [8:0] latch_set;

  generate
    for (gi = 0; gi < 9; gi++) begin : g_flag
      wire logic rd_hit = (gi <= 4) ? rd_first : rd_second;
      wire logic clr = ~err_s[gi] & (clear_on_recover | rd_hit);
      assign flag_next[gi] = (err_s[gi] & (resp[gi] != 2'd0)) |
                             (flag_reg[gi] & ~clr);
      assign auto_off[gi]  = err_s[gi] & (resp[gi] == 2'd2);
      assign latch_set[gi] = err_s[gi] & (resp[gi] == 2'd3);
    end
  endgenerate

  // set wins over release
  wire logic latch_next = (|latch_set) | (latch_reg & ~latch_release);
  wire logic pin_active = cfg_reg[0][3] ? latch_next : (|flag_next);
  wire logic pin_level  = cfg_reg[0][2] ? pin_active : ~pin_active;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      flag_reg      <= 9'h000;
      latch_reg     <= 1'b0;
      eoff_reg      <= 1'b0;
      fault_pin_reg <= 1'b1;
    end else begin
      flag_reg      <= flag_next;
      latch_reg     <= latch_next;
      eoff_reg      <= latch_next | (|auto_off);
      fault_pin_reg <= pin_level;
    end
  end

  // ========================================================================
  // read data
  assign rdata =
    (addr_reg <= `PDCFG_OFS_RUNTIME_LOCK) ? cfg_reg[addr_reg[3:0]] :
    (addr_reg == `PDCFG_OFS_FLAGS_FIRST)  ? {3'h0, flag_reg[4:0]} :
    (addr_reg == `PDCFG_OFS_FLAGS_SECOND) ? {4'h0, flag_reg[8:5]} :
    8'h00;

  // ========================================================================
  // decoded controls
  pdcfg_ctl_s ctl_reg;
  pdcfg_ctl_s ctl_next;
  wire logic [3:0] oc_blank  = cfg_reg[5][3:0];
  wire logic [1:0] oc_code   = cfg_reg[5][5:4];
  wire logic [1:0] deb_code  = cfg_reg[6][3:2];
  wire logic [1:0] mask_code = cfg_reg[6][1:0];
  wire logic [3:0] dead_code = cfg_reg[7][3:0];
  wire logic [2:0] wdt_code  = cfg_reg[4][6:4];

  always_comb begin
    ctl_next = '0;
    ctl_next.thermal_threshold_select = cfg_reg[0][5];
    ctl_next.warn_temp_c     = cfg_reg[0][5] ? `PDCFG_TEMP_MID_C :
                                               `PDCFG_TEMP_LOW_C;
    ctl_next.shutdown_temp_c = cfg_reg[0][5] ? `PDCFG_TEMP_HIGH_C :
                                               `PDCFG_TEMP_MID_C;
    ctl_next.gate_voltage_select      = cfg_reg[0][1];
    ctl_next.regulator_voltage_select = cfg_reg[0][0];
    ctl_next.sense_offset_select      = cfg_reg[4][2];
    ctl_next.three_input_drive_select = cfg_reg[4][0];
    ctl_next.overcurrent_threshold_code = oc_code;
    ctl_next.overcurrent_threshold_mv =
      (oc_code == 2'd0) ? `PDCFG_OC_MV_0 :
      (oc_code == 2'd1) ? `PDCFG_OC_MV_1 : `PDCFG_OC_MV_2;
    ctl_next.oc_blank_cycles = 9'((10'(oc_blank) + 10'd1) *
                                  10'(`PDCFG_BLANK_STEP_CYC));
    ctl_next.short_debounce_cycles = 9'((10'(deb_code) + 10'd1) *
                                        10'(`PDCFG_DEBOUNCE_STEP_CYC));
    ctl_next.short_blank_cycles = 11'((12'(mask_code) + 12'd1) *
                                      12'(`PDCFG_SHORT_MASK_STEP_CYC));
    ctl_next.min_dead_cycles = 9'((10'(`PDCFG_DEAD_CODES) - 10'(dead_code))
                                  * 10'(`PDCFG_BLANK_STEP_CYC));
    ctl_next.watchdog_window_code = wdt_code;
    ctl_next.wdt_first_cycles  = WDT_FIRST_CYC >> wdt_code;
    ctl_next.wdt_closed_cycles = WDT_CLOSED_CYC >> wdt_code;
    ctl_next.wdt_window_cycles = WDT_WINDOW_CYC >> wdt_code;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ctl_reg <= '0;
    end else begin
      ctl_reg <= ctl_next;
    end
  end

  // ========================================================================
  // outputs
  assign miso          = miso_reg;
  assign ctl           = ctl_reg;
  assign emergency_off = eoff_reg;
  assign latched_off   = latch_reg;
  assign fault_pin     = fault_pin_reg;
  assign fault_flags   = flag_reg;
  assign wdt_restart   = wdt_restart_reg;
  assign nv_reload     = reload_reg;

endmodule

// file: verif/pdcfg_bank_props.sv
// port checker: decode tables, fault paths and command pulses
// assumes binding into pdcfg_bank; fault_in passes two sync flops
`timescale 1ns/1ps

module pdcfg_bank_props
  import pdcfg_pkg::*;
#(
  parameter logic [31:0] WDT_FIRST_CYC  = 32'h1,
  parameter logic [31:0] WDT_CLOSED_CYC = 32'h1,
  parameter logic [31:0] WDT_WINDOW_CYC = 32'h1,
  parameter logic [31:0] RELOAD_CYC     = 32'h2
) (
  input wire logic       core_clk,
  input wire logic       rst_n,
  input wire logic [8:0] fault_in,
  input wire pdcfg_ctl_s ctl,
  input wire logic       emergency_off,
  input wire logic       latched_off,
  input wire logic [8:0] fault_flags,
  input wire logic       wdt_restart,
  input wire logic       nv_reload
);
  // =====
  // helpers: fault history, cycles since last reload
  logic [8:0]  fd [1:5];
  logic [31:0] gap_cnt;
  wire  [8:0]  recent = fd[2] | fd[3] | fd[4] | fd[5];

  always_ff @(posedge core_clk) begin
    fd[1] <= fault_in;
    for (int k = 2; k <= 5; k++) fd[k] <= fd[k-1];
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n || nv_reload) gap_cnt <= 32'h0;
    else if (gap_cnt != 32'hffffffff) gap_cnt <= gap_cnt + 32'h1;
  end

  // =====
  // properties
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_live;
    $past(rst_n);
  endsequence
  sequence s_pulse;
    wdt_restart ##1 !wdt_restart;
  endsequence

  a_temp_pair: assert property (
    s_live |-> ctl.shutdown_temp_c == (ctl.thermal_threshold_select ?
    8'd175 : 8'd150) && ctl.warn_temp_c == (ctl.thermal_threshold_select ?
    8'd150 : 8'd125)) else $error("thermal pair wrong");
  a_oc_level: assert property (
    s_live |-> ctl.overcurrent_threshold_mv ==
    (ctl.overcurrent_threshold_code == 2'h0 ? 8'd200 :
    ctl.overcurrent_threshold_code == 2'h1 ? 8'd150 : 8'd100))
    else $error("overcurrent level wrong");
  a_timing_grid: assert property (
    s_live |-> ctl.oc_blank_cycles % 20 == 0 &&
    ctl.oc_blank_cycles inside {[20:320]} &&
    ctl.short_debounce_cycles % 80 == 0 &&
    ctl.short_debounce_cycles inside {[80:320]} &&
    ctl.short_blank_cycles % 320 == 0 &&
    ctl.short_blank_cycles inside {[320:1280]} &&
    ctl.min_dead_cycles % 20 == 0 && ctl.min_dead_cycles inside {[20:320]})
    else $error("timing count off grid");
  a_wdt_halving: assert property (
    s_live |-> ctl.wdt_first_cycles == (WDT_FIRST_CYC >>
    ctl.watchdog_window_code) && ctl.wdt_closed_cycles == (WDT_CLOSED_CYC >>
    ctl.watchdog_window_code) && ctl.wdt_window_cycles == (WDT_WINDOW_CYC >>
    ctl.watchdog_window_code)) else $error("watchdog window wrong");
  a_latch_eoff: assert property (
    latched_off |-> emergency_off) else $error("latch without off");
  a_latch_cause: assert property (
    $rose(latched_off) |-> recent[1:0] != 2'h0)
    else $error("latch without fault");
  a_eoff_cause: assert property (
    emergency_off |-> latched_off || recent != 9'h000)
    else $error("off without cause");
  a_flag_cause: assert property (
    s_live |-> (fault_flags & ~$past(fault_flags) & ~recent) == 9'h000)
    else $error("flag without fault");
  a_restart_pulse: assert property (
    $rose(wdt_restart) |-> s_pulse) else $error("restart not one cycle");
  a_reload_gap: assert property (
    nv_reload |-> gap_cnt >= RELOAD_CYC - 32'd2)
    else $error("reload too early");
endmodule

bind pdcfg_bank pdcfg_bank_props #(.WDT_FIRST_CYC(WDT_FIRST_CYC),
  .WDT_CLOSED_CYC(WDT_CLOSED_CYC), .WDT_WINDOW_CYC(WDT_WINDOW_CYC),
  .RELOAD_CYC(RELOAD_CYC)) u_pdcfg_bank_props (.core_clk(core_clk),
  .rst_n(rst_n), .fault_in(fault_in), .ctl(ctl),
  .emergency_off(emergency_off), .latched_off(latched_off),
  .fault_flags(fault_flags), .wdt_restart(wdt_restart),
  .nv_reload(nv_reload));

// file: verif/pdcfg_spi_host.sv
// serial host model: mode-0 frames of 16 bits paced by the core clock
// assumes lines change just after rising core_clk edges
`timescale 1ns/1ps

module pdcfg_spi_host (
  input  wire logic core_clk,
  input  wire logic miso,
  output logic      sclk,
  output logic      cs_n,
  output logic      mosi
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end

  // =====
  // one frame: rw, address, data; read bits taken at rises
  task automatic xfer(input logic [15:0] fr, input int half,
                      output logic [7:0] rdat);
    rdat = 8'h00;
    @(posedge core_clk);
    cs_n <= 1'b0;
    for (int k = 15; k >= 0; k--) begin
      mosi <= fr[k];
      repeat (half) @(posedge core_clk);
      sclk <= 1'b1;
      if (k < 8) rdat[k] = miso;
      repeat (half) @(posedge core_clk);
      sclk <= 1'b0;
    end
    repeat (half) @(posedge core_clk);
    cs_n <= 1'b1;
    mosi <= ~fr[0];
  endtask
endmodule

// file: verif/pdcfg_bank_tb_top.sv
// bench: register traffic, decode sweeps, fault responses
// assumes the serial host model and the bound port checker
`timescale 1ns/1ps
`include "pdcfg_defs.svh"

module pdcfg_bank_tb_top
  import pdcfg_pkg::*;
;
  localparam logic [31:0] WF = 32'd4096, WC = 32'd1024, WW = 32'd2048;
  logic       core_clk = 1'b0, rst_n = 1'b0, drive_enable = 1'b0;
  logic       sclk, cs_n, mosi, miso, emergency_off, latched_off;
  logic       fault_pin, wdt_restart, nv_reload;
  logic [8:0] fault_in = 9'h000, fault_flags;
  logic [7:0] rd, d;
  logic [6:0] a;
  logic [7:0] sh [8] = '{default: 8'h00};
  logic [7:0] mtab [8] = '{`PDCFG_MASK_0, `PDCFG_MASK_1, `PDCFG_MASK_2,
    `PDCFG_MASK_3, `PDCFG_MASK_4, `PDCFG_MASK_5, `PDCFG_MASK_6,
    `PDCFG_MASK_7};
  pdcfg_nv_s  nv_config = '0;
  pdcfg_ctl_s ctl;
  int         failures = 0, n_checks = 0, seed = 73, cycles = 0;
  int         h = 5, n_rst = 0, n_rl = 0, i;

  pdcfg_bank #(.WDT_FIRST_CYC(WF), .WDT_CLOSED_CYC(WC),
    .WDT_WINDOW_CYC(WW), .RELOAD_CYC(32'd50)) u_pdcfg_bank (
    .core_clk(core_clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n),
    .mosi(mosi), .miso(miso), .drive_enable(drive_enable),
    .nv_config(nv_config), .fault_in(fault_in), .ctl(ctl),
    .emergency_off(emergency_off), .latched_off(latched_off),
    .fault_pin(fault_pin), .fault_flags(fault_flags),
    .wdt_restart(wdt_restart), .nv_reload(nv_reload));
  pdcfg_spi_host u_pdcfg_spi_host (.core_clk(core_clk), .miso(miso),
    .sclk(sclk), .cs_n(cs_n), .mosi(mosi));

  initial forever #5 core_clk = ~core_clk;

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (wdt_restart === 1'b1) n_rst <= n_rst + 1;
    if (nv_reload === 1'b1) n_rl <= n_rl + 1;
    if (cycles == 90000) begin
      failures = failures + 1;
      final_report();
    end
  end

  // =====
  // helpers
  function automatic int oc_mv(input int c);
    return c == 0 ? 200 : (c == 1 ? 150 : 100);
  endfunction
  task automatic final_report();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [6:0] ad, input logic [7:0] dt);
    u_pdcfg_spi_host.xfer({1'b1, ad, dt}, h, rd);
    repeat (4) @(posedge core_clk);
  endtask
  task automatic rdc(input logic [6:0] ad, input logic [7:0] e);
    u_pdcfg_spi_host.xfer({1'b0, ad, 8'h00}, h, rd);
    repeat (4) @(posedge core_clk);
    chk($sformatf("reg %0h", ad), e, rd);
  endtask
  task automatic flt(input logic [8:0] f);
    fault_in <= f;
    repeat (8) @(posedge core_clk);
  endtask

  // =====
  // main sequence
  initial begin
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    for (i = 0; i < 9; i++) rdc(i[6:0], 8'h00);
    chk("pin", 1, fault_pin);
    for (i = 0; i < 16; i++) begin
      a = 7'($unsigned($random(seed)) % 8);
      d = 8'($random(seed));
      h = 5 + $unsigned($random(seed)) % 4;
      wr(a, d);
      if (a != 7'h03) sh[a] = d & mtab[a];
      rdc(a, sh[a]);
    end
    h = 5;
    wr(7'h04, 8'h00);
    sh[4] = 8'h00;
    drive_enable <= 1'b1;
    for (i = 0; i < 8; i++) wr(i[6:0], 8'h5a);
    for (i = 0; i < 8; i++) rdc(i[6:0], sh[i]);
    wr(7'h15, 8'h00);
    chk("restart", 1, n_rst);
    drive_enable <= 1'b0;
    rdc(7'h30, 8'h00);
    for (i = 0; i < 16; i++) begin
      d = 8'(i | (i << 4));
      wr(7'h05, d);
      wr(7'h06, d);
      wr(7'h07, d);
      wr(7'h04, d & 8'h75);
      wr(7'h00, d);
      chk("blank", 20 * (i + 1), ctl.oc_blank_cycles);
      chk("ocmv", oc_mv(i % 4), ctl.overcurrent_threshold_mv);
      chk("deb", 80 * (i / 4 + 1), ctl.short_debounce_cycles);
      chk("smask", 320 * (i % 4 + 1), ctl.short_blank_cycles);
      chk("dead", 20 * (16 - i), ctl.min_dead_cycles);
      chk("wdt", WF >> (i % 8), ctl.wdt_first_cycles);
      chk("wdtc", WC >> (i % 8), ctl.wdt_closed_cycles);
      chk("wdtw", WW >> (i % 8), ctl.wdt_window_cycles);
      chk("drv3", i % 2, ctl.three_input_drive_select);
      chk("offs", (i / 4) % 2, ctl.sense_offset_select);
      chk("tsd", (i / 2) % 2 ? 175 : 150, ctl.shutdown_temp_c);
      chk("gate", (i / 2) % 2, ctl.gate_voltage_select);
      chk("regv", i % 2, ctl.regulator_voltage_select);
    end
    wr(7'h00, 8'h00);
    wr(7'h01, 8'h04);
    wr(7'h07, 8'he0);
    flt(9'h014);
    chk("flags", 9'h004, fault_flags);
    chk("eoff", 0, emergency_off);
    chk("pin", 0, fault_pin);
    flt(9'h000);
    chk("hold", 9'h004, fault_flags);
    rdc(7'h20, 8'h04);
    chk("clr", 0, fault_flags);
    flt(9'h001);
    chk("eoff", 1, emergency_off);
    flt(9'h000);
    chk("recover", 0, emergency_off);
    flt(9'h002);
    flt(9'h000);
    chk("latch", 1, latched_off);
    chk("eoff", 1, emergency_off);
    wr(7'h15, 8'hff);
    chk("unlatch", 0, latched_off);
    rdc(7'h20, 8'h03);
    wr(7'h00, 8'h1c);
    wr(7'h01, 8'h10);
    flt(9'h010);
    chk("eoff", 1, emergency_off);
    chk("pin", 0, fault_pin);
    flt(9'h000);
    chk("auto", 0, fault_flags);
    wr(7'h00, 8'h14);
    flt(9'h010);
    chk("pin", 1, fault_pin);
    flt(9'h000);
    for (i = 0; i < 4; i++) begin
      wr(7'h01, 8'(i | ((i & 2) << 2)));
      wr(7'h02, 8'(i * 21));
      flt(9'h1e8);
      chk("sflag", (i ? 9'h1e0 : 0) | (i > 1 ? 9'h008 : 0),
          fault_flags);
      chk("soff", i > 1, emergency_off);
      flt(9'h000);
    end
    nv_config <= pdcfg_nv_s'($random(seed)) | 25'h1000000;
    wr(7'h04, 8'h02);
    drive_enable <= 1'b1;
    repeat (120) @(posedge core_clk);
    drive_enable <= 1'b0;
    chk("reload", 1, n_rl > 1);
    rdc(7'h00, nv_config.diag_supply & mtab[0]);
    rdc(7'h03, 8'h01);
    wr(7'h00, ~nv_config.diag_supply);
    rdc(7'h00, nv_config.diag_supply & mtab[0]);
    wr(7'h08, 8'h01);
    wr(7'h05, 8'h00);
    rdc(7'h05, 8'h3f);
    final_report();
  end
endmodule
